/* design/three_pin_port.sv */
// Three-pin port with serial pin sharing, pull-ups and mode-dependent pin states
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module three_pin_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Operating mode: sleep, subsleep and watch share the hold request
    input wire logic holdMode,
    input wire logic standbyMode,
    // Serial unit side
    input wire logic serialDataOut,
    input wire logic serialClockOut,
    output logic serialDataIn,
    output logic serialClockIn,
    // Pins
    input wire logic [2:0] pinIn,
    output logic [2:0] pinOut,
    output logic [2:0] pinOe,
    output logic [2:0] pullupOn
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0] portData;
    logic [2:0] pinDirection;
    logic [2:0] pinPullupEnable;
    logic [2:0] pinFunctionSelect;
    logic serialClockSource;
    logic [2:0] pinSync1;
    logic [2:0] pinSync2;
    port_mux_pkg::op_mode_t mode;
    port_mux_pkg::op_mode_t next_mode;

    wire writeData = regWrite && regAddr == port_mux_pkg::OFS_DATA;
    wire writeDir = regWrite && regAddr == port_mux_pkg::OFS_DIRECTION;
    wire writePull = regWrite && regAddr == port_mux_pkg::OFS_PULLUP;
    wire writeFunc = regWrite && regAddr == port_mux_pkg::OFS_FUNCTION;
    wire writeSer = regWrite && regAddr == port_mux_pkg::OFS_SERIAL_CTRL;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            portData <= 3'h0;
            pinDirection <= 3'h0;
            pinPullupEnable <= 3'h0;
            pinFunctionSelect <= 3'h0;
            serialClockSource <= 1'h0;
        end else begin
            if (writeData) portData <= regWdata[2:0];
            if (writeDir) pinDirection <= regWdata[2:0];
            if (writePull) pinPullupEnable <= regWdata[2:0];
            if (writeFunc) pinFunctionSelect <= regWdata[2:0];
            if (writeSer) serialClockSource <= regWdata[port_mux_pkg::BIT_CLOCK_SOURCE];
        end
    end

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= 3'h0;
            pinSync2 <= 3'h0;
        end else begin
            pinSync1 <= pinIn;
            pinSync2 <= pinSync1;
        end
    end

    // ------------------------------------------------------------
    // Mode tracking; standby wins over hold
    // ------------------------------------------------------------
    always_comb begin
        if (standbyMode) next_mode = port_mux_pkg::MODE_STANDBY;
        else if (holdMode) next_mode = port_mux_pkg::MODE_HOLD;
        else next_mode = port_mux_pkg::MODE_RUN;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) mode <= port_mux_pkg::MODE_RUN;
        else mode <= next_mode;
    end

    // ------------------------------------------------------------
    // Per-pin selection
    // ------------------------------------------------------------
    logic [2:0] cellOut;
    logic [2:0] cellOe;
    logic [2:0] cellPull;
    logic [2:0] serialSelect;
    logic [2:0] serialDrives;
    logic [2:0] serialSource;

    assign serialSelect = pinFunctionSelect;
    assign serialDrives[port_mux_pkg::BIT_DATA_OUT] = 1'b1;
    assign serialDrives[port_mux_pkg::BIT_DATA_IN] = 1'b0;
    assign serialDrives[port_mux_pkg::BIT_CLOCK] = ~serialClockSource;
    assign serialSource[port_mux_pkg::BIT_DATA_OUT] = serialDataOut;
    assign serialSource[port_mux_pkg::BIT_DATA_IN] = 1'b0;
    assign serialSource[port_mux_pkg::BIT_CLOCK] = serialClockOut;

    genvar i;
    generate
        for (i = 0; i < port_mux_pkg::PIN_COUNT; i++) begin : g_pin
            port_pin_cell u_cell (
                .serialSelect(serialSelect[i]),
                .serialDrives(serialDrives[i]),
                .direction(pinDirection[i]),
                .pullupEnable(pinPullupEnable[i]),
                .portData(portData[i]),
                .serialOut(serialSource[i]),
                .pinOut(cellOut[i]),
                .pinOe(cellOe[i]),
                .pullupOn(cellPull[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin outputs by mode
    // ------------------------------------------------------------
    // Standby floats the pin but lets the pull-up hold it high
    wire [2:0] standbyPull = cellPull;
    logic [2:0] next_pinOut;
    logic [2:0] next_pinOe;
    logic [2:0] next_pullupOn;

    always_comb begin
        unique case (mode)
            port_mux_pkg::MODE_RUN: begin
                next_pinOut = cellOut;
                next_pinOe = cellOe;
                next_pullupOn = cellPull;
            end
            port_mux_pkg::MODE_HOLD: begin
                next_pinOut = pinOut;
                next_pinOe = pinOe;
                next_pullupOn = pullupOn;
            end
            default: begin
                next_pinOut = 3'h0;
                next_pinOe = 3'h0;
                next_pullupOn = standbyPull;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut <= 3'h0;
            pinOe <= 3'h0;
            pullupOn <= 3'h0;
            serialDataIn <= 1'h0;
            serialClockIn <= 1'h0;
        end else begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
            pullupOn <= next_pullupOn;
            serialDataIn <= serialSelect[port_mux_pkg::BIT_DATA_IN]
                & pinSync2[port_mux_pkg::BIT_DATA_IN];
            serialClockIn <= serialSelect[port_mux_pkg::BIT_CLOCK] & serialClockSource
                & pinSync2[port_mux_pkg::BIT_CLOCK];
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    // Direction is write-only and reads as all ones
    logic [7:0] readMux;
    always_comb begin
        unique case (regAddr)
            port_mux_pkg::OFS_DATA: readMux = {5'h00, portData};
            port_mux_pkg::OFS_DIRECTION: readMux = port_mux_pkg::WRITE_ONLY_READ;
            port_mux_pkg::OFS_PULLUP: readMux = {5'h00, pinPullupEnable};
            port_mux_pkg::OFS_FUNCTION: readMux = {5'h00, pinFunctionSelect};
            port_mux_pkg::OFS_SERIAL_CTRL: readMux = {7'h00, serialClockSource};
            port_mux_pkg::OFS_PIN_STATE: readMux = {5'h00, pinSync2};
            default: readMux = port_mux_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) regRdata <= 8'h00;
        else if (regRead) regRdata <= readMux;
        else regRdata <= 8'h00;
    end
endmodule : three_pin_port

/* common/port_mux_pkg.sv */
// Constants for the three-pin port with serial-channel pin sharing
//
// Contract
// - Function select 0: pin two is general I/O by direction; 1: serial data out.
// - Function select 0: pin one general I/O by direction; 1: serial data in.
// - Pin zero: select 1 carries serial clock, input if clock-source bit is 1.
// - General I/O direction 1 means output, 0 means input; directions reset to 0.
// - Pins float in reset, hold in sleep/subsleep/watch, work in active/subactive.
// - In standby pins float, but a pin with pull-up on shows high.
// - Pull-up is on only when direction is 0 and pull-up enable is 1.
// - Each of the three pins has its own writable pull-up enable bit.
// - After reset every pull-up is off until software enables it.
package port_mux_pkg;
    localparam int PIN_COUNT = 3;
    localparam int ADDR_W = 4;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_DIRECTION = 4'h1;
    localparam logic [3:0] OFS_PULLUP = 4'h2;
    localparam logic [3:0] OFS_FUNCTION = 4'h3;
    localparam logic [3:0] OFS_SERIAL_CTRL = 4'h4;
    localparam logic [3:0] OFS_PIN_STATE = 4'h5;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_CLOCK = 0;
    localparam int BIT_DATA_IN = 1;
    localparam int BIT_DATA_OUT = 2;
    localparam int BIT_CLOCK_SOURCE = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] WRITE_ONLY_READ = 8'hFF;
    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN = 3'h1,
        MODE_HOLD = 3'h2,
        MODE_STANDBY = 3'h4
    } op_mode_t;
endpackage : port_mux_pkg

/* design/port_pin_cell.sv */
// One pin's output, enable and pull-up selection
`timescale 1ns/1ns
module port_pin_cell (
    // Configuration
    input wire logic serialSelect,
    input wire logic serialDrives,
    input wire logic direction,
    input wire logic pullupEnable,
    // Sources
    input wire logic portData,
    input wire logic serialOut,
    // Results
    output logic pinOut,
    output logic pinOe,
    output logic pullupOn
);
    assign pinOut = serialSelect ? serialOut : portData;
    assign pinOe = serialSelect ? serialDrives : direction;
    assign pullupOn = pullupEnable & ~direction;
endmodule : port_pin_cell

/* verification/three_pin_port_assertions.sv */
// Checker for pin selection, pull-up and mode behaviour of the three-pin port
`timescale 1ns/1ns
module three_pin_port_checker (
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // Modes, serial unit and pins
    input wire logic holdMode,
    input wire logic standbyMode,
    input wire logic serialDataOut,
    input wire logic serialClockIn,
    input wire logic [2:0] pinIn,
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    input wire logic [2:0] pullupOn
);
    logic [2:0] fn, dir, pul, quiet;
    logic src;
    wire settled = quiet == 3'h5;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Shadow copies; enable, pull-up and serial pin checks wait for five quiet cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {fn, dir, pul, src, quiet} <= 13'h0000;
        end else begin
            if (regWrite && regAddr == port_mux_pkg::OFS_FUNCTION) fn <= regWdata[2:0];
            if (regWrite && regAddr == port_mux_pkg::OFS_DIRECTION) dir <= regWdata[2:0];
            if (regWrite && regAddr == port_mux_pkg::OFS_PULLUP) pul <= regWdata[2:0];
            if (regWrite && regAddr == port_mux_pkg::OFS_SERIAL_CTRL) src <= regWdata[0];
            quiet <= (regWrite || holdMode || standbyMode || $changed(pinIn)
                || $changed(serialDataOut)) ? 3'h0 : quiet + 3'(quiet != 3'h5);
        end
    end
    sequence holdSteady; (holdMode && !standbyMode)[*3]; endsequence
    sequence standbySteady; standbyMode[*3]; endsequence
    reset_float_a: assert property ($rose(rst_n) |-> pinOe == 3'h0 && pullupOn == 3'h0)
        else $error("pins active after reset");
    hold_freeze_a: assert property (holdSteady |=> $stable(pinOe) && $stable(pinOut)
        && $stable(pullupOn)) else $error("pins moved in hold");
    standby_float_a: assert property (standbySteady |=> pinOe == 3'h0 && pinOut == 3'h0)
        else $error("pins driven in standby");
    oe_select_a: assert property (settled |-> pinOe ==
        {fn[2] | dir[2], ~fn[1] & dir[1], fn[0] ? ~src : dir[0]}) else $error("wrong enable");
    pull_only_a: assert property (settled |-> (pullupOn & ~(pul & ~dir)) == 3'h0)
        else $error("pull-up on without cause");
    data_out_a: assert property (settled && fn[2] |-> pinOut[2] == serialDataOut)
        else $error("serial data not on pin two");
    clock_in_a: assert property (settled && fn[0] && src |-> serialClockIn == pinIn[0])
        else $error("serial clock not taken from pin zero");
    pull_read_a: assert property (regRead && regAddr == port_mux_pkg::OFS_PULLUP |=>
        regRdata == {5'h00, $past(pul)}) else $error("pull-up enable read back wrong");
endmodule : three_pin_port_checker
bind three_pin_port three_pin_port_checker i_three_pin_port_checker (.sys_clk, .rst_n,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .holdMode, .standbyMode,
    .serialDataOut, .serialClockIn, .pinIn, .pinOut, .pinOe, .pullupOn);

/* verification/far_side_model.sv */
// Serial unit and external pin wiring seen by the three-pin port
`timescale 1ns/1ns
module far_side_model (
    // Control from the bench
    input wire logic sys_clk,
    input wire logic serialRun,
    input wire logic [2:0] extDrive,
    input wire logic [2:0] extLevel,
    // Port pin side
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    input wire logic [2:0] pullupOn,
    output logic [2:0] pinIn,
    output logic serialDataOut,
    output logic serialClockOut
);
    logic [3:0] tick = 4'h0;
    logic drift = 1'b0;
    always_ff @(posedge sys_clk) begin
        tick <= serialRun ? tick + 4'h1 : tick;
        drift <= ~drift;
    end
    // Clock stands still when the unit is idle
    assign serialClockOut = serialRun & tick[1];
    assign serialDataOut = tick[3];
    // A floating pin wanders so a stale level never passes as a match
    assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel)
        | (~pinOe & ~extDrive & (pullupOn | {3{drift}}));
endmodule : far_side_model

/* verification/tb_top.sv */
// Register-driven bench for the three-pin port
`timescale 1ns/1ns
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, regWrite, regRead, holdMode, standbyMode, serialRun;
    logic serialDataOut, serialClockOut, serialDataIn, serialClockIn;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [2:0] pinIn, pinOut, pinOe, pullupOn, extDrive, extLevel;
    int errTotal = 0, numChecks = 0, cycles = 0;
    three_pin_port i_three_pin_port (.sys_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .holdMode, .standbyMode, .serialDataOut, .serialClockOut, .serialDataIn,
        .serialClockIn, .pinIn, .pinOut, .pinOe, .pullupOn);
    far_side_model i_far_side_model (.sys_clk, .serialRun, .extDrive, .extLevel, .pinOut,
        .pinOe, .pullupOn, .pinIn, .serialDataOut, .serialClockOut);
    always #25 sys_clk = ~sys_clk;
    task reportAndStop();
        $display("Checks %0d, mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : reportAndStop
    // Far beyond the run's length, so only a hang reaches it
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errTotal++;
            reportAndStop();
        end
    end
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : waitc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
        @(posedge sys_clk);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 chk(name, e, regRdata);
    endtask : rd
    initial begin
        {regAddr, regWdata, regWrite, regRead, holdMode, standbyMode, serialRun} = 17'h00000;
        {extDrive, extLevel} = 6'h38;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        waitc(1);
        chk("reset oe", 8'h00, 8'(pinOe));
        chk("reset pull", 8'h00, 8'(pullupOn));
        rd(port_mux_pkg::OFS_DIRECTION, port_mux_pkg::WRITE_ONLY_READ, "dir read");
        rd(4'hF, 8'h00, "unmapped read");
        wr(port_mux_pkg::OFS_DATA, 8'h05);
        wr(port_mux_pkg::OFS_DIRECTION, 8'h06);
        waitc(3);
        chk("gpio oe", 8'h06, 8'(pinOe));
        chk("gpio out", 8'h04, 8'(pinOut & pinOe));
        rd(port_mux_pkg::OFS_DATA, 8'h05, "data read");
        @(posedge sys_clk) holdMode <= 1'b1;
        wr(port_mux_pkg::OFS_DIRECTION, 8'h07);
        waitc(4);
        chk("hold oe", 8'h06, 8'(pinOe));
        @(posedge sys_clk) holdMode <= 1'b0;
        waitc(4);
        chk("run oe", 8'h07, 8'(pinOe));
        wr(port_mux_pkg::OFS_PULLUP, 8'hFF);
        wr(port_mux_pkg::OFS_DIRECTION, 8'h06);
        waitc(3);
        chk("pull on", 8'h01, 8'(pullupOn));
        rd(port_mux_pkg::OFS_PULLUP, 8'h07, "pull read");
        @(posedge sys_clk) {standbyMode, extDrive} <= 4'hE;
        waitc(4);
        chk("standby oe", 8'h00, 8'(pinOe));
        chk("standby pull", 8'h01, 8'(pullupOn));
        chk("standby level", 8'h01, 8'(pinIn[0]));
        @(posedge sys_clk) {standbyMode, serialRun, extDrive, extLevel} <= 8'h7F;
        wr(port_mux_pkg::OFS_DIRECTION, 8'h07);
        wr(port_mux_pkg::OFS_FUNCTION, 8'h07);
        waitc(6);
        chk("serial oe", 8'h05, 8'(pinOe));
        chk("serial in", 8'h01, 8'(serialDataIn));
        wr(port_mux_pkg::OFS_SERIAL_CTRL, 8'h01);
        waitc(6);
        chk("clock in oe", 8'h04, 8'(pinOe));
        chk("clock in", 8'h01, 8'(serialClockIn));
        rd(port_mux_pkg::OFS_SERIAL_CTRL, 8'h01, "clock source read");
        // Low levels prove both serial inputs follow their pins
        @(posedge sys_clk) extLevel <= 3'h4;
        waitc(5);
        chk("clock in low", 8'h00, 8'(serialClockIn));
        chk("serial in low", 8'h00, 8'(serialDataIn));
        @(posedge sys_clk) rst_n <= 1'b0;
        waitc(2);
        chk("mid reset oe", 8'h00, 8'(pinOe));
        @(posedge sys_clk) {rst_n, extLevel} <= 4'hF;
        rd(port_mux_pkg::OFS_PULLUP, port_mux_pkg::RESET_BYTE, "pull after reset");
        rd(port_mux_pkg::OFS_FUNCTION, port_mux_pkg::RESET_BYTE, "fn after reset");
        waitc(2);
        // High pins with no serial function must not reach the serial unit
        chk("data in unselected", 8'h00, 8'(serialDataIn));
        chk("clock in unselected", 8'h00, 8'(serialClockIn));
        rd(port_mux_pkg::OFS_PIN_STATE, 8'h07, "pin state read");
        wr(port_mux_pkg::OFS_PULLUP, 8'h05);
        waitc(3);
        chk("pull per pin", 8'h05, 8'(pullupOn));
        rd(port_mux_pkg::OFS_PULLUP, 8'h05, "pull read per pin");
        reportAndStop();
    end
endmodule : tb_top
